// *** design/bias_corrector.sv ***
// pairwise debiasing of the raw noise stream
`timescale 1ns/1ps
`default_nettype none

module bias_corrector (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            clear_i,
    input  wire logic            enable_i,
    input  wire rng_pkg::noise_t raw_i,
    output var  rng_pkg::noise_t out_o
);
    import rng_pkg::*;

    typedef struct packed {
        logic   have_first;
        logic   first_bit;
        noise_t out;
    } bc_state_t;

    bc_state_t st;
    bc_state_t next_st;

    // pairs 01 and 10 give one bit, equal pairs are dropped, so the rate varies
    always_comb begin
        next_st           = st;
        next_st.out.valid = 1'b0;
        if (clear_i) begin
            next_st.have_first = 1'b0;
        end else if (raw_i.valid) begin
            if (!enable_i) begin
                next_st.out.valid   = 1'b1;
                next_st.out.bit_val = raw_i.bit_val;
            end else if (!st.have_first) begin
                next_st.have_first = 1'b1;
                next_st.first_bit  = raw_i.bit_val;
            end else begin
                next_st.have_first = 1'b0;
                if (st.first_bit != raw_i.bit_val) begin
                    next_st.out.valid   = 1'b1;
                    next_st.out.bit_val = st.first_bit;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign out_o = st.out;
endmodule

`default_nettype wire

// *** design/byte_assembler.sv ***
// eight-bit shift stage that collects corrected bits into a byte
`timescale 1ns/1ps
`default_nettype none

module byte_assembler (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            clear_i,
    input  wire rng_pkg::noise_t bit_i,
    output logic [7:0]           byte_o,
    output logic                 done_o
);
    import rng_pkg::*;

    typedef struct packed {
        logic [7:0] shreg;
        logic [2:0] count;
        logic [7:0] result;
        logic       done;
    } ba_state_t;

    ba_state_t st;
    ba_state_t next_st;

    // new bits enter at bit 0; the eighth bit completes a byte
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (clear_i) begin
            next_st.count = 3'h0;
        end else if (bit_i.valid) begin
            next_st.shreg = {st.shreg[6:0], bit_i.bit_val};
            next_st.count = st.count + 3'h1;
            if (st.count == 3'h7) begin
                next_st.result = {st.shreg[6:0], bit_i.bit_val};
                next_st.done   = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign byte_o = st.result;
    assign done_o = st.done;
endmodule

`default_nettype wire

// *** design/rng_defs.svh ***
// offsets, field positions, reset values and timing counts of the random byte generator
`ifndef RNG_DEFS_SVH
`define RNG_DEFS_SVH

`define OFS_START_TRIGGER    12'h000
`define OFS_STOP_TRIGGER     12'h004
`define OFS_READY_EVENT_FLAG 12'h100
`define OFS_SHORTCUT_CONTROL 12'h200
`define OFS_IRQ_ENABLE_SET   12'h304
`define OFS_IRQ_ENABLE_CLEAR 12'h308
`define OFS_GENERATOR_CONFIG 12'h504
`define OFS_RANDOM_RESULT    12'h508

`define BIT_TRIGGER          0
`define BIT_READY_STOP       0
`define BIT_READY_IRQ        0
`define BIT_BIAS_CORRECTION  0

`define RST_RANDOM_RESULT    8'h00

`define CLK_FREQ_HZ          25000000
`define STARTUP_DELAY_US     128
`define STARTUP_CYCLES       ((`STARTUP_DELAY_US * (`CLK_FREQ_HZ / 1000) + 999) / 1000)
`define STARTUP_CNT_W        13

`endif

// *** design/rng_pkg.sv ***
// types shared by the random byte generator files
package rng_pkg;

    typedef enum logic [1:0] {
        GEN_IDLE    = 2'b00,
        GEN_WARMUP  = 2'b01,
        GEN_RUNNING = 2'b10
    } gen_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        bit_val;
        logic        valid;
    } noise_t;

endpackage

// *** design/true_random_byte_generator.sv ***
// top of the random byte generator: wishbone registers, run control and result
// Operation
// - writing start trigger begins generation, writing stop trigger halts it
// - while running, bytes keep coming without further triggers
// - every loaded byte sets the ready event flag
// - result is overwritten by each new byte, read or not
// - corrected bits shift into an eight-bit stage, read in parallel
// - bias correction removes one/zero preference at a lower byte rate
// - interval between ready events varies; no fixed rate assumed
// - shortcut bit 0 makes each ready event also stop generation
// - writing 1 to enable-set turns the ready interrupt on; reads show it
// - writing 1 to enable-clear turns the ready interrupt off; reads show it
// - config bit 0 enables bias correction, reset 0
// - result register holds the byte in bits 7..0, upper bits zero
// - generation needs no seed, only the noise input
// - start waits about 128 us once, not between bytes
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "rng_defs.svh"

module true_random_byte_generator
    import rng_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         cyc_i,
    input  wire logic         stb_i,
    input  wire logic         we_i,
    input  wire logic [3:0]   sel_i,
    input  wire logic [11:0]  adr_i,
    input  wire logic [31:0]  dat_i,
    output logic [31:0]       dat_o,
    output logic              ack_o,
    output logic              err_o,
    input  wire logic         noise_bit_i,
    input  wire logic         noise_valid_i,
    output logic              irq_o,
    output logic              running_o
);
    import rng_pkg::*;

    // ==========================================================
    // register map
    // ==========================================================
    // every field except random_result (bits 7..0) sits in bit 0 of its 32-bit word; upper bits read zero
    //   0x000 start_trigger     write 1: leave idle and begin the warm-up
    //   0x004 stop_trigger      write 1: back to idle, a partial byte is lost
    //   0x100 ready_event_flag  set by each byte, cleared by writing 0
    //   0x200 shortcut_control  ready_stop_shortcut: a byte also stops the run
    //   0x304 irq_enable_set    write 1 sets the ready enable, reads it back
    //   0x308 irq_enable_clear  write 1 clears the ready enable, reads it back
    //   0x504 generator_config  bias_correction_enable
    //   0x508 random_result     latest whole byte, read only
    // triggers read as zero; only byte lane 0 gates writes
    // any other offset is answered with err and changes nothing

    // ==========================================================
    // notes for users
    // ==========================================================
    // - the byte rate follows the noise strobe and, with correction on,
    //   the share of unequal pairs; software waits for the flag,
    //   never for a fixed number of cycles
    // - a stop during warm-up or mid-byte loses only the partial byte;
    //   the result register keeps the last whole byte
    // - a byte and a clear of the flag in one cycle leave the flag set,
    //   so no event is lost, at the cost of one extra interrupt
    // - no seed exists: after reset the result reads zero until the
    //   first byte of a run has been collected
    // - the warm-up is counted in clock cycles, so it scales with the clock

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        // run control
        gen_state_t                 gen;
        logic [`STARTUP_CNT_W-1:0]  warm_cnt;
        // software-visible fields
        logic                       ready_flag;
        logic                       ready_stop;
        logic                       irq_en;
        logic                       bias_en;
        logic [7:0]                 result;
        // bus answer
        logic [31:0]                rdata;
        logic                       ack;
        logic                       err;
        // output pins
        logic                       irq;
        logic                       running;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    // bus request and the links between the two datapath stages
    wb_req_t    req;
    noise_t     raw;
    noise_t     fixed_bit;
    logic [7:0] new_byte;
    logic       byte_done;
    logic       gen_clear;

    // last warm-up count; the counter starts at zero on the start write
    localparam logic [`STARTUP_CNT_W-1:0] WARM_LAST = `STARTUP_CNT_W'(`STARTUP_CYCLES - 1);

    // ==========================================================
    // bus request and noise capture
    // ==========================================================
    assign req.cyc = cyc_i;
    assign req.stb = stb_i;
    assign req.we  = we_i;
    assign req.sel = sel_i;
    assign req.adr = adr_i;
    assign req.dat = dat_i;

    // noise accepted only while producing; no seed register exists.
    // bits offered during the warm-up are dropped, so the first byte of a
    // run is built from noise taken after the source has settled
    assign raw.bit_val = noise_bit_i;
    assign raw.valid   = noise_valid_i && (st.gen == GEN_RUNNING);

    // partial bytes are thrown away whenever not running
    assign gen_clear = (st.gen != GEN_RUNNING);

    // ==========================================================
    // datapath
    // ==========================================================
    // pairs first, then bytes; each stage adds one register of latency
    bias_corrector bias_corrector_inst (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (gen_clear),
        .enable_i (st.bias_en),
        .raw_i    (raw),
        .out_o    (fixed_bit)
    );

    byte_assembler byte_assembler_inst (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (gen_clear),
        .bit_i   (fixed_bit),
        .byte_o  (new_byte),
        .done_o  (byte_done)
    );

    // ==========================================================
    // address decode
    // ==========================================================
    // true for the eight offsets that answer with ack
    function automatic logic is_mapped(input logic [11:0] adr);
        case (adr)
            `OFS_START_TRIGGER,
            `OFS_STOP_TRIGGER,
            `OFS_READY_EVENT_FLAG,
            `OFS_SHORTCUT_CONTROL,
            `OFS_IRQ_ENABLE_SET,
            `OFS_IRQ_ENABLE_CLEAR,
            `OFS_GENERATOR_CONFIG,
            `OFS_RANDOM_RESULT: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // a write of 1 into one bit of one register, gated by byte lane 0
    function automatic logic wr_one(input wb_req_t r, input logic [11:0] ofs, input int pos);
        wr_one = (r.adr == ofs) && r.sel[0] && r.dat[pos];
    endfunction

    // ==========================================================
    // request decode
    // ==========================================================
    // a request seen while no answer stands is taken on that edge and
    // answered one cycle later; the answer lasts a single cycle, so a
    // master that keeps stb up past its ack is taken again one cycle after the ack.
    // writes act on the taking edge; read data is registered with ack.
    logic bus_take;
    logic bus_mapped;
    logic bus_write;
    logic bus_read;

    assign bus_take   = req.cyc && req.stb && !st.ack && !st.err;
    assign bus_mapped = is_mapped(req.adr);
    assign bus_write  = bus_take && req.we && bus_mapped;
    assign bus_read   = bus_take && !req.we;

    // one word of read data with a single field in bit 0
    function automatic logic [31:0] flag_word(input logic b);
        flag_word = {31'h0000_0000, b};
    endfunction

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        logic take;
        logic do_wr;
        logic start_hit;
        logic stop_hit;
        logic loaded;
        take      = 1'b0;
        do_wr     = 1'b0;
        start_hit = 1'b0;
        stop_hit  = 1'b0;
        loaded    = 1'b0;
        next_st   = st;

        // ==========================================================
        // bus answer
        // one-cycle ack; the cycle after an ack is always idle on the bus
        take        = bus_take;
        do_wr       = bus_write;
        next_st.ack = take && bus_mapped;
        next_st.err = take && !bus_mapped;

        start_hit = do_wr && wr_one(req, `OFS_START_TRIGGER, `BIT_TRIGGER);
        stop_hit  = do_wr && wr_one(req, `OFS_STOP_TRIGGER, `BIT_TRIGGER);

        // byte arrival only counts while running; no rate assumed
        loaded = byte_done && (st.gen == GEN_RUNNING);

        // ==========================================================
        // control registers
        // only byte lane 0 carries fields, so other lanes change nothing
        if (do_wr && req.sel[0]) begin
            case (req.adr)
                `OFS_SHORTCUT_CONTROL: begin
                    // obeyed from the next byte on
                    next_st.ready_stop = req.dat[`BIT_READY_STOP];
                end
                `OFS_GENERATOR_CONFIG: begin
                    // best changed while stopped: a half pair survives the switch
                    next_st.bias_en = req.dat[`BIT_BIAS_CORRECTION];
                end
                `OFS_IRQ_ENABLE_SET: begin
                    // set and clear registers let software touch one enable safely
                    if (req.dat[`BIT_READY_IRQ]) begin
                        next_st.irq_en = 1'b1;
                    end
                end
                `OFS_IRQ_ENABLE_CLEAR: begin
                    if (req.dat[`BIT_READY_IRQ]) begin
                        next_st.irq_en = 1'b0;
                    end
                end
                `OFS_READY_EVENT_FLAG: begin
                    // writing 1 does nothing, so a copy-back cannot raise the flag
                    if (!req.dat[0]) begin
                        next_st.ready_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // ==========================================================
        // result and event; a new byte wins over a same-cycle clear
        if (loaded) begin
            next_st.result     = new_byte;
            next_st.ready_flag = 1'b1;
        end

        // ==========================================================
        // run control; stop wins over a simultaneous start
        case (st.gen)
            GEN_IDLE: begin
                // a stop while idle is only acknowledged
                if (start_hit && !stop_hit) begin
                    next_st.gen      = GEN_WARMUP;
                    next_st.warm_cnt = '0;
                end
            end
            GEN_WARMUP: begin
                // counted in clock cycles: another clock rate needs new timing counts
                if (stop_hit) begin
                    next_st.gen = GEN_IDLE;
                end else if (st.warm_cnt == WARM_LAST) begin
                    next_st.gen = GEN_RUNNING;
                end else begin
                    next_st.warm_cnt = st.warm_cnt + `STARTUP_CNT_W'(1);
                end
            end
            GEN_RUNNING: begin
                // stays running across bytes with no new warm-up
                if (stop_hit || (loaded && st.ready_stop)) begin
                    next_st.gen = GEN_IDLE;
                end
            end
            default: next_st.gen = GEN_IDLE;
        endcase

        // ==========================================================
        // read data, registered with the ack
        // triggers and unmapped offsets read as zero
        next_st.rdata = 32'h0000_0000;
        if (bus_read) begin
            case (req.adr)
                `OFS_READY_EVENT_FLAG: next_st.rdata = flag_word(st.ready_flag);
                `OFS_SHORTCUT_CONTROL: next_st.rdata = flag_word(st.ready_stop);
                `OFS_IRQ_ENABLE_SET:   next_st.rdata = flag_word(st.irq_en);
                `OFS_IRQ_ENABLE_CLEAR: next_st.rdata = flag_word(st.irq_en);
                `OFS_GENERATOR_CONFIG: next_st.rdata = flag_word(st.bias_en);
                `OFS_RANDOM_RESULT:    next_st.rdata = {24'h0, st.result};
                default:               next_st.rdata = 32'h0000_0000;
            endcase
        end

        // level interrupt from the next flag and enable
        next_st.irq = next_st.ready_flag && next_st.irq_en;

        // status pin kept as its own flop rather than a decode of the state
        next_st.running = (next_st.gen == GEN_RUNNING);
    end

    // ==========================================================
    // registers
    // ==========================================================
    // synchronous reset: every field clears, so pins and enables start low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st        <= '0;
            st.gen    <= GEN_IDLE;
            st.result <= `RST_RANDOM_RESULT;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign dat_o     = st.rdata;
    assign ack_o     = st.ack;
    assign err_o     = st.err;
    assign irq_o     = st.irq;
    assign running_o = st.running;
endmodule

`default_nettype wire

// *** dv/true_random_byte_generator_props.sv ***
// concurrent checks on the ports of the random byte generator
`timescale 1ns/1ps
`default_nettype none
`include "rng_defs.svh"

module true_random_byte_generator_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  sel_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        err_o,
    input wire logic        noise_bit_i,
    input wire logic        noise_valid_i,
    input wire logic        irq_o,
    input wire logic        running_o
);
    logic        start_q;
    logic        stop_q;
    logic        clr_q;
    logic [12:0] warm_cnt;
    wire logic   wr_one = cyc_i && stb_i && we_i && sel_i[0] && dat_i[0] && !ack_o;

    // ===========================================
    // helper: which write is being acked, cycles since start
    always_ff @(posedge clk_i) begin
        start_q  <= wr_one && adr_i == `OFS_START_TRIGGER;
        stop_q   <= wr_one && adr_i == `OFS_STOP_TRIGGER;
        clr_q    <= wr_one && adr_i == `OFS_IRQ_ENABLE_CLEAR;
        if (rst_i || (ack_o && start_q)) begin
            warm_cnt <= rst_i ? 13'h1FFF : 13'h0000;
        end else if (warm_cnt != 13'h1FFF) begin
            warm_cnt <= warm_cnt + 13'h0001;
        end
    end

    // ===========================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    a_bus_answer: assert property ((cyc_i && stb_i && !ack_o && !err_o) |=> (ack_o ^ err_o))
        else $error("request not answered in one cycle");
    a_err_unmapped: assert property (err_o |-> !($past(adr_i) inside {`OFS_START_TRIGGER, `OFS_STOP_TRIGGER,
        `OFS_READY_EVENT_FLAG, `OFS_SHORTCUT_CONTROL, `OFS_IRQ_ENABLE_SET, `OFS_IRQ_ENABLE_CLEAR,
        `OFS_GENERATOR_CONFIG, `OFS_RANDOM_RESULT})) else $error("error on mapped address");
    a_idle_data_zero: assert property (!ack_o |-> dat_o == 32'h00000000) else $error("read data outside ack");
    a_result_upper_zero: assert property ((ack_o && $past(adr_i) == `OFS_RANDOM_RESULT) |->
        dat_o[31:8] == 24'h000000) else $error("result upper bits not zero");
    a_stop_halts: assert property ((ack_o && stop_q) |-> !running_o) else $error("still running after stop");
    a_irq_off_clear: assert property ((ack_o && clr_q) |=> !irq_o) else $error("irq after enable clear");
    a_warmup_time: assert property ($rose(running_o) |-> warm_cnt inside {[13'h0C76:13'h0C8A]})
        else $error("warm-up length wrong");
    a_ack_err_apart: assert property (!(ack_o && err_o)) else $error("ack and err together");
endmodule

`default_nettype wire

// *** dv/true_random_byte_generator_test.sv ***
// self-checking bench for the random byte generator
`timescale 1ns/1ps
`default_nettype none

module true_random_byte_generator_test;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [3:0]  sel_i = 4'h0;
    logic [11:0] adr_i = 12'h000;
    logic [31:0] dat_i = 32'h00000000;
    logic        noise_bit_i = 1'b0;
    logic        noise_valid_i = 1'b0;
    logic [31:0] dat_o;
    logic        ack_o, err_o, irq_o, running_o;
    logic [31:0] rd;
    logic        er;
    int          failures = 0;
    int          samples_checked = 0;
    logic [11:0] offs [7] = '{12'h000, 12'h100, 12'h200, 12'h304, 12'h308, 12'h504, 12'h508};

    true_random_byte_generator true_random_byte_generator_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i),
        .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .noise_bit_i(noise_bit_i), .noise_valid_i(noise_valid_i), .irq_o(irq_o), .running_o(running_o));

    // ===========================================
    // clock, 40 ns period
    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic summarize;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle, held until ack or err is sampled high
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
        rd = dat_o;
        er = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (n >= 20) begin
            failures++;
            summarize();
        end
        @(posedge clk_i);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    // noise bits, first bit of v[n-1] first, one per cycle
    task automatic feed(input logic [19:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk_i);
            noise_bit_i <= v[i];
            noise_valid_i <= 1'b1;
        end
        @(posedge clk_i);
        noise_valid_i <= 1'b0;
        noise_bit_i <= ~noise_bit_i;
        repeat (4) @(posedge clk_i);
    endtask

    // warm-up is long, so the bound leaves margin over 3200 cycles
    task automatic start_run;
        int n;
        n = 0;
        wb(1'b1, 12'h000, 32'h00000001);
        while (running_o !== 1'b1 && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 5000) begin
            failures++;
            summarize();
        end
    endtask

    // ===========================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (offs[i]) rdchk(offs[i], 32'h00000000);
        wb(1'b0, 12'h00C, 32'h00000000);
        chk({31'h00000000, er}, 32'h00000001);
        wb(1'b1, 12'h504, 32'h00000001);
        rdchk(12'h504, 32'h00000001);
        wb(1'b1, 12'h504, 32'h00000000);
        rdchk(12'h504, 32'h00000000);
        wb(1'b1, 12'h304, 32'h00000001);
        rdchk(12'h304, 32'h00000001);
        rdchk(12'h308, 32'h00000001);
        start_run();
        feed(20'h0A55A, 16);
        rdchk(12'h508, 32'h0000005A);
        rdchk(12'h100, 32'h00000001);
        chk({31'h00000000, irq_o}, 32'h00000001);
        wb(1'b1, 12'h100, 32'h00000000);
        rdchk(12'h100, 32'h00000000);
        chk({31'h00000000, irq_o}, 32'h00000000);
        wb(1'b1, 12'h308, 32'h00000001);
        rdchk(12'h304, 32'h00000000);
        wb(1'b1, 12'h004, 32'h00000001);
        chk({31'h00000000, running_o}, 32'h00000000);
        wb(1'b1, 12'h504, 32'h00000001);
        start_run();
        feed(20'h5E8A5, 20);
        rdchk(12'h508, 32'h0000003C);
        wb(1'b1, 12'h004, 32'h00000001);
        wb(1'b1, 12'h504, 32'h00000000);
        wb(1'b1, 12'h200, 32'h00000001);
        rdchk(12'h200, 32'h00000001);
        start_run();
        feed(20'h000C3, 8);
        rdchk(12'h508, 32'h000000C3);
        chk({31'h00000000, running_o}, 32'h00000000);
        summarize();
    end
endmodule

bind true_random_byte_generator true_random_byte_generator_props true_random_byte_generator_props_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .noise_bit_i(noise_bit_i), .noise_valid_i(noise_valid_i), .irq_o(irq_o), .running_o(running_o));

`default_nettype wire
